// >>> rtl/hsc_heater_ctrl.sv
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module hsc_heater_ctrl #(
	parameter int unsigned TICK_CYCLES = hsc_pkg::TICK_CYCLES_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [8:0]  virtual_temp_k,
	input  wire logic [15:0] housing_temp_dc,
	input  wire logic [5:0]  supply_volt,
	input  wire logic        plaus_fail,
	output logic             heater_on
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  mode;
		logic        plaus_en;
		logic [8:0]  low_thr;
		logic [8:0]  high_thr;
		logic [5:0]  vmin;
		logic [15:0] house_thr;
		logic [31:0] rdata;
		logic        err;
		logic        demand;
		logic        heat_req;
		logic        heater;
	} hsc_state_t;

	hsc_state_t s_r;
	hsc_state_t s_nxt;

	logic        ramp_drive;
	logic        ramp_full;
	logic        ramp_run;
	logic [6:0]  ramp_on_time;
	logic        ramp_en;

	// ----------------------------------------------------------------
	// Soft-start ramp
	// ----------------------------------------------------------------
	hsc_ramp #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_ramp (
		.clk_sys (clk_sys),
		.rst     (rst),
		.enable  (ramp_en),
		.drive   (ramp_drive),
		.full    (ramp_full),
		.ramping (ramp_run),
		.on_time (ramp_on_time)
	);

	// ----------------------------------------------------------------
	// Byte-lane merge
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Heating decision terms
	// ----------------------------------------------------------------
	logic house_mode;
	logic auto_mode;
	logic vt_cold;
	logic vt_warm;
	logic house_cold;
	logic plaus_heat;
	logic volt_low;

	always_comb begin
		house_mode = (s_r.mode == hsc_pkg::MODE_HOUSE_A) ||
			(s_r.mode == hsc_pkg::MODE_HOUSE_B) ||
			(s_r.mode == hsc_pkg::MODE_HOUSE_C);
		auto_mode  = house_mode ||
			(s_r.mode == hsc_pkg::MODE_AUTO_VT);
		vt_cold    = virtual_temp_k < s_r.low_thr;
		vt_warm    = virtual_temp_k > s_r.high_thr;
		house_cold = house_mode && ($signed(housing_temp_dc) <
			$signed(s_r.house_thr));
		plaus_heat = s_r.plaus_en && plaus_fail;
		volt_low   = supply_volt < s_r.vmin;
	end

	// ----------------------------------------------------------------
	// Register access and control
	// ----------------------------------------------------------------
	logic        setup;
	logic        wr_acc;
	logic        known;
	logic [31:0] cur;
	logic [31:0] wv;
	logic        wr_ok;
	logic [31:0] stat;

	always_comb begin
		s_nxt  = s_r;
		setup  = psel && !penable;
		wr_acc = psel && penable && pwrite;
		known  = 1'b1;
		cur    = '0;
		stat   = '0;

		stat[hsc_pkg::STAT_HEATER] = s_r.heater;
		stat[hsc_pkg::STAT_REQ]    = s_r.heat_req;
		stat[hsc_pkg::STAT_DEMAND] = s_r.demand;
		stat[hsc_pkg::STAT_VLOW]   = volt_low;
		stat[hsc_pkg::STAT_FULL]   = ramp_full;
		stat[hsc_pkg::STAT_RAMP]   = ramp_run;
		stat[hsc_pkg::STAT_ONT_MSB:hsc_pkg::STAT_ONT_LSB] = ramp_on_time;

		if (paddr == hsc_pkg::ADDR_MODE) begin
			cur[hsc_pkg::MODE_MSB:hsc_pkg::MODE_LSB] = s_r.mode;
			cur[hsc_pkg::PLAUS_EN_BIT] = s_r.plaus_en;
		end else if (paddr == hsc_pkg::ADDR_LOW) begin
			cur[8:0] = s_r.low_thr;
		end else if (paddr == hsc_pkg::ADDR_HIGH) begin
			cur[8:0] = s_r.high_thr;
		end else if (paddr == hsc_pkg::ADDR_VMIN) begin
			cur[5:0] = s_r.vmin;
		end else if (paddr == hsc_pkg::ADDR_HOUSE) begin
			cur[15:0] = s_r.house_thr;
		end else if (paddr == hsc_pkg::ADDR_STAT) begin
			cur = stat;
		end else if (paddr == hsc_pkg::ADDR_TEMP) begin
			cur[hsc_pkg::TEMP_VT_MSB:hsc_pkg::TEMP_VT_LSB] =
				virtual_temp_k;
			cur[hsc_pkg::TEMP_HOUSE_MSB:hsc_pkg::TEMP_HOUSE_LSB] =
				housing_temp_dc;
		end else if (paddr == hsc_pkg::ADDR_PWR) begin
			cur[5:0] = supply_volt;
		end else begin
			known = 1'b0;
		end

		// Write value with byte lanes applied; range checked below
		wv    = merge(cur, pwdata, pstrb);
		wr_ok = known;
		if (paddr == hsc_pkg::ADDR_MODE) begin
			wr_ok = wv[hsc_pkg::MODE_MSB:hsc_pkg::MODE_LSB] <=
				hsc_pkg::MODE_DIRECT;
		end else if (paddr == hsc_pkg::ADDR_LOW ||
			paddr == hsc_pkg::ADDR_HIGH) begin
			wr_ok = (wv[8:0] >= hsc_pkg::THR_MIN) &&
				(wv[8:0] <= hsc_pkg::THR_MAX);
		end else if (paddr == hsc_pkg::ADDR_VMIN) begin
			wr_ok = (wv[5:0] >= hsc_pkg::VMIN_MIN) &&
				(wv[5:0] <= hsc_pkg::VMIN_MAX);
		end else if (paddr == hsc_pkg::ADDR_STAT ||
			paddr == hsc_pkg::ADDR_TEMP ||
			paddr == hsc_pkg::ADDR_PWR) begin
			wr_ok = 1'b0;
		end

		// Read data and error are prepared in the setup cycle
		if (setup) begin
			s_nxt.rdata = pwrite ? 32'h0000_0000 : cur;
			s_nxt.err   = pwrite ? !wr_ok : !known;
		end

		if (wr_acc && wr_ok) begin
			if (paddr == hsc_pkg::ADDR_MODE) begin
				s_nxt.mode     = wv[hsc_pkg::MODE_MSB:hsc_pkg::MODE_LSB];
				s_nxt.plaus_en = wv[hsc_pkg::PLAUS_EN_BIT];
			end else if (paddr == hsc_pkg::ADDR_LOW) begin
				s_nxt.low_thr = wv[8:0];
			end else if (paddr == hsc_pkg::ADDR_HIGH) begin
				s_nxt.high_thr = wv[8:0];
			end else if (paddr == hsc_pkg::ADDR_VMIN) begin
				s_nxt.vmin = wv[5:0];
			end else if (paddr == hsc_pkg::ADDR_HOUSE) begin
				s_nxt.house_thr = wv[15:0];
			end
		end

		// Automatic demand with hysteresis between the two thresholds
		if (!auto_mode) begin
			s_nxt.demand = 1'b0;
		end else if (vt_cold || house_cold || plaus_heat) begin
			s_nxt.demand = 1'b1;
		end else if (vt_warm) begin
			s_nxt.demand = 1'b0;
		end

		// Mode decode gated by the supply check
		case (s_r.mode)
			hsc_pkg::MODE_OFF: begin
				s_nxt.heat_req = 1'b0;
			end
			hsc_pkg::MODE_ON: begin
				s_nxt.heat_req = !volt_low;
			end
			hsc_pkg::MODE_DIRECT: begin
				s_nxt.heat_req = !volt_low;
			end
			default: begin
				s_nxt.heat_req = !volt_low && auto_mode &&
					s_r.demand;
			end
		endcase

		// Direct mode bypasses the ramp; every other heater ramps
		if (s_r.mode == hsc_pkg::MODE_DIRECT) begin
			s_nxt.heater = s_r.heat_req;
		end else begin
			s_nxt.heater = s_r.heat_req && ramp_drive;
		end
	end

	assign ramp_en = s_r.heat_req &&
		(s_r.mode != hsc_pkg::MODE_DIRECT);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r <= '{mode: hsc_pkg::RST_MODE,
				plaus_en: hsc_pkg::RST_PLAUS_EN,
				low_thr: hsc_pkg::RST_LOW,
				high_thr: hsc_pkg::RST_HIGH,
				vmin: hsc_pkg::RST_VMIN,
				house_thr: hsc_pkg::RST_HOUSE,
				rdata: 32'h0000_0000,
				err: 1'b0,
				demand: 1'b0,
				heat_req: 1'b0,
				heater: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pready    = 1'b1;
	assign prdata    = s_r.rdata;
	assign pslverr   = s_r.err && psel && penable;
	assign heater_on = s_r.heater;

endmodule

// >>> rtl/hsc_pkg.sv
package hsc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE  = 8'h00;
	localparam logic [7:0] ADDR_LOW   = 8'h04;
	localparam logic [7:0] ADDR_HIGH  = 8'h08;
	localparam logic [7:0] ADDR_VMIN  = 8'h0C;
	localparam logic [7:0] ADDR_HOUSE = 8'h10;
	localparam logic [7:0] ADDR_STAT  = 8'h14;
	localparam logic [7:0] ADDR_TEMP  = 8'h18;
	localparam logic [7:0] ADDR_PWR   = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_LSB       = 0;
	localparam int MODE_MSB       = 2;
	localparam int PLAUS_EN_BIT   = 3;
	localparam int STAT_HEATER    = 0;
	localparam int STAT_REQ       = 1;
	localparam int STAT_DEMAND    = 2;
	localparam int STAT_VLOW      = 3;
	localparam int STAT_FULL      = 4;
	localparam int STAT_RAMP      = 5;
	localparam int STAT_ONT_LSB   = 8;
	localparam int STAT_ONT_MSB   = 14;
	localparam int TEMP_VT_LSB    = 0;
	localparam int TEMP_VT_MSB    = 8;
	localparam int TEMP_HOUSE_LSB = 16;
	localparam int TEMP_HOUSE_MSB = 31;

	// ----------------------------------------------------------------
	// Heating modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_OFF     = 3'h0;
	localparam logic [2:0] MODE_AUTO_VT = 3'h1;
	localparam logic [2:0] MODE_ON      = 3'h2;
	localparam logic [2:0] MODE_HOUSE_A = 3'h3;
	localparam logic [2:0] MODE_HOUSE_B = 3'h4;
	localparam logic [2:0] MODE_HOUSE_C = 3'h5;
	localparam logic [2:0] MODE_DIRECT  = 3'h6;

	// ----------------------------------------------------------------
	// Reset values and legal ranges
	// ----------------------------------------------------------------
	localparam logic [2:0]  RST_MODE     = 3'h1;
	localparam logic        RST_PLAUS_EN = 1'b0;
	localparam logic [8:0]  RST_LOW      = 9'h113;
	localparam logic [8:0]  RST_HIGH     = 9'h118;
	localparam logic [5:0]  RST_VMIN     = 6'h0A;
	localparam logic [15:0] RST_HOUSE    = 16'h0014;
	localparam logic [8:0]  THR_MIN      = 9'h0DC;
	localparam logic [8:0]  THR_MAX      = 9'h140;
	localparam logic [5:0]  VMIN_MIN     = 6'h05;
	localparam logic [5:0]  VMIN_MAX     = 6'h30;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 50;
	localparam int TICK_NS         = 1000000;
	localparam int TICK_MS         = 1;
	localparam int RAMP_PERIOD_MS  = 100;
	localparam int RAMP_START_MS   = 1;
	localparam int RAMP_STEP_MS    = 5;
	localparam int RAMP_FULL_MS    = 2000;
	localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
	localparam logic [6:0] PERIOD_TICKS =
		7'(RAMP_PERIOD_MS / TICK_MS);
	localparam logic [6:0] START_TICKS = 7'(RAMP_START_MS / TICK_MS);
	localparam logic [6:0] STEP_TICKS  = 7'(RAMP_STEP_MS / TICK_MS);
	localparam logic [4:0] RAMP_PERIODS =
		5'(RAMP_FULL_MS / RAMP_PERIOD_MS);

	typedef enum logic [1:0] {
		RAMP_IDLE,
		RAMP_RUN,
		RAMP_FULL
	} hsc_ramp_st_t;

endpackage

// >>> rtl/hsc_ramp.sv
`timescale 1ns/10ps
module hsc_ramp #(
	parameter int unsigned TICK_CYCLES = hsc_pkg::TICK_CYCLES_DEF
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       enable,
	output logic            drive,
	output logic            full,
	output logic            ramping,
	output logic [6:0]      on_time
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		hsc_pkg::hsc_ramp_st_t st;
		logic [15:0]           presc;
		logic [6:0]            phase;
		logic [6:0]            on_time;
		logic [4:0]            periods;
		logic                  drive;
	} hsc_ramp_state_t;

	hsc_ramp_state_t s_r;
	hsc_ramp_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			hsc_pkg::RAMP_IDLE: begin
				s_nxt.presc   = '0;
				s_nxt.phase   = '0;
				s_nxt.periods = '0;
				s_nxt.on_time = hsc_pkg::START_TICKS;
				if (enable) begin
					s_nxt.st = hsc_pkg::RAMP_RUN;
				end
			end
			hsc_pkg::RAMP_RUN: begin
				if (s_r.presc == 16'(TICK_CYCLES - 1)) begin
					s_nxt.presc = '0;
					if (s_r.phase == hsc_pkg::PERIOD_TICKS - 7'h1) begin
						s_nxt.phase   = '0;
						s_nxt.periods = s_r.periods + 5'h1;
						if (s_r.periods + 5'h1 == hsc_pkg::RAMP_PERIODS) begin
							s_nxt.st = hsc_pkg::RAMP_FULL;
						end else begin
							s_nxt.on_time = s_r.on_time +
								hsc_pkg::STEP_TICKS;
						end
					end else begin
						s_nxt.phase = s_r.phase + 7'h1;
					end
				end else begin
					s_nxt.presc = s_r.presc + 16'h0001;
				end
			end
			default: begin
			end
		endcase
		// Any switch-off restarts the ramp
		if (!enable) begin
			s_nxt.st = hsc_pkg::RAMP_IDLE;
		end
		s_nxt.drive = (s_nxt.st == hsc_pkg::RAMP_FULL) ||
			((s_nxt.st == hsc_pkg::RAMP_RUN) &&
			(s_nxt.phase < s_nxt.on_time));
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r <= '{st: hsc_pkg::RAMP_IDLE, presc: 16'h0000,
				phase: 7'h00, on_time: 7'h01, periods: 5'h00,
				drive: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign drive   = s_r.drive;
	assign full    = (s_r.st == hsc_pkg::RAMP_FULL);
	assign ramping = (s_r.st == hsc_pkg::RAMP_RUN);
	assign on_time = s_r.on_time;

endmodule

// >>> tb/hsc_heater_properties.sv
`timescale 1ns/10ps
module hsc_chk #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic [8:0]  virtual_temp_k,
	input wire logic [15:0] housing_temp_dc,
	input wire logic [5:0]  supply_volt,
	input wire logic        plaus_fail,
	input wire logic        heater_on
);
	localparam int PER = 100 * TICK_CYCLES;
	logic [2:0]  mode_r;
	logic [8:0]  low_r, high_r;
	logic [5:0]  vmin_r;
	logic [15:0] hi_r, lo_r, t_r;
	logic [3:0]  want_r;
	logic        pe_r, wr, ok, am, hcold, want;
	// ------------------------------------
	// Shadow settings and run counters
	// ------------------------------------
	assign wr = psel && penable && pwrite && !pslverr;
	assign ok = supply_volt >= vmin_r;
	assign am = mode_r == 3'h1 || (mode_r >= 3'h3 && mode_r <= 3'h5);
	assign hcold = mode_r != 3'h1
		&& $signed(housing_temp_dc) < $signed(16'h0014);
	assign want = ok && (mode_r == 3'h2 || mode_r == 3'h6
		|| am && (virtual_temp_k < low_r || hcold || pe_r && plaus_fail));
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_r <= 3'h1;
			pe_r   <= 1'b0;
			low_r  <= 9'h113;
			high_r <= 9'h118;
			vmin_r <= 6'h0a;
			hi_r   <= '0;
			lo_r   <= 16'hffff;
			t_r    <= '0;
			want_r <= '0;
		end else begin
			if (wr && paddr == 8'h00) begin
				mode_r <= pwdata[2:0];
				pe_r   <= pwdata[3];
			end
			if (wr && paddr == 8'h04)
				low_r <= pwdata[8:0];
			if (wr && paddr == 8'h08)
				high_r <= pwdata[8:0];
			if (wr && paddr == 8'h0c)
				vmin_r <= pwdata[5:0];
			hi_r <= heater_on ? hi_r + 16'h1 : '0;
			lo_r <= heater_on ? '0 : lo_r + 16'(lo_r != 16'hffff);
			// A rise after a gap longer than any ramp gap restarts the ramp
			if (heater_on && lo_r > 16'(PER - 2))
				t_r <= 16'h1;
			else
				t_r <= t_r + 16'(t_r != 16'hffff);
			want_r <= want ? want_r + 4'(want_r != 4'hf) : '0;
		end
	end
	// ------------------------------------
	// Properties
	// ------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence ramp_fall;
		mode_r == 3'h2 && ok && $fell(heater_on);
	endsequence
	sequence full_run;
		(mode_r == 3'h2 && ok && t_r > 16'(20 * PER + 2))[*8];
	endsequence
	ramp_pulse_a: assert property (ramp_fall
		|-> hi_r == TICK_CYCLES * (1 + 5 * (t_r / PER)))
		else $error("ramp pulse length wrong");
	ramp_full_a: assert property (full_run |-> heater_on)
		else $error("heater not full on after ramp");
	heat_want_a: assert property (
		want_r > 4'h8 |-> lo_r < 16'(PER))
		else $error("heater idle while heat is wanted");
	mode_off_a: assert property ((mode_r == 3'h0)[*5] |-> !heater_on)
		else $error("heater on in off mode");
	auto_off_a: assert property (
		(am && virtual_temp_k > high_r && !hcold
		&& !(pe_r && plaus_fail))[*6]
		|-> !heater_on)
		else $error("heater on above high threshold");
	supply_cut_a: assert property ((!ok)[*5] |-> !heater_on)
		else $error("heater on with low supply");
	direct_on_a: assert property ((mode_r == 3'h6 && ok)[*5]
		|-> heater_on)
		else $error("direct mode not steady on");
	range_refuse_a: assert property (psel && penable && pwrite
		&& (paddr == 8'h04 && !(pwdata[8:0] inside {[9'h0dc:9'h140]})
		|| paddr == 8'h0c && !(pwdata[5:0] inside {[6'h05:6'h30]}))
		|-> pslverr)
		else $error("out of range setting accepted");
endmodule
bind hsc_heater_ctrl hsc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pslverr, .virtual_temp_k, .housing_temp_dc, .supply_volt,
	.plaus_fail, .heater_on);

// >>> tb/hsc_sensor_model.sv
`timescale 1ns/10ps
module hsc_sensor_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [8:0]  vt_set,
	input  wire logic [15:0] house_set,
	input  wire logic [5:0]  volt_set,
	input  wire logic        fail_set,
	output logic [8:0]       virtual_temp_k,
	output logic [15:0]      housing_temp_dc,
	output logic [5:0]       supply_volt,
	output logic             plaus_fail
);
	// --------------------------------------
	// Sensors settle one clock after a change
	// --------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			virtual_temp_k  <= 9'h12c;
			housing_temp_dc <= 16'h0100;
			supply_volt     <= 6'h18;
			plaus_fail      <= 1'b0;
		end else begin
			virtual_temp_k  <= vt_set;
			housing_temp_dc <= house_set;
			supply_volt     <= volt_set;
			plaus_fail      <= fail_set;
		end
	end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam int TK = 4;
	localparam int PER = 100 * TK;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, heater_on, plaus_fail, er;
	logic [8:0]  vt_set = 9'h12c, virtual_temp_k;
	logic [15:0] house_set = 16'h0100, housing_temp_dc;
	logic [5:0]  volt_set = 6'h18, supply_volt;
	logic        fail_set = 1'b0;
	int          bad_count = 0, cmp_count = 0;
	int          h, d, v, hs, md, pf, exp_q[$];
	logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c};
	int          rv[8] = '{3'h1, 9'h113, 9'h118, 6'h0a, 16'h0014,
		32'h0000_0100, 32'h0100_012c, 6'h18};
	logic [7:0]  wa[11] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h0c, 8'h0c,
		8'h0c, 8'h0c, 8'h00, 8'h14, 8'h1c};
	int          wd[11] = '{9'h0db, 9'h141, 9'h0dc, 9'h113, 6'h04, 6'h31,
		6'h30, 6'h0a, 4'h7, 1'h1, 1'h1};
	int          we[11] = '{1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 1};
	int          modes[5] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h9};
	always #25 clk_sys = ~clk_sys;
	hsc_heater_ctrl #(.TICK_CYCLES(TK)) dut (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .pready, .prdata, .pslverr, .virtual_temp_k,
		.housing_temp_dc, .supply_volt, .plaus_fail, .heater_on);
	hsc_sensor_model u_model (
		.clk_sys, .rst, .vt_set, .house_set, .volt_set, .fail_set,
		.virtual_temp_k, .housing_temp_dc, .supply_volt, .plaus_fail);
	// ----------------------
	// Stimulus tasks
	// ----------------------
	task automatic check(string nm, logic [31:0] seen, logic [31:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] dt);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= dt;
		@(posedge clk_sys);
		penable <= 1'b1;
		// pready is tied high, so this wait ends after one cycle
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic count_high(int n);
		h = 0;
		repeat (n) begin
			@(posedge clk_sys);
			h += int'(heater_on === 1'b1);
		end
	endtask
	task automatic wait_rise();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (heater_on !== 1'b1 && n < 50);
		check("heater rise", 32'(n < 50), 32'h1);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		complete_run();
	end
	// ----------------------
	// Test sequence
	// ----------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		void'($urandom(32'h0000_ebb3));
		foreach (ra[i]) begin
			apb(1'b0, ra[i], '0);
			check("reset value", rd, rv[i]);
			check("read error", 32'(er), 32'h0);
		end
		foreach (wa[i]) begin
			apb(1'b1, wa[i], wd[i]);
			check("write refused", 32'(er), we[i]);
		end
		apb(1'b0, 8'h20, '0);
		check("unmapped error", {rd[30:0], er}, 32'h1);
		apb(1'b1, 8'h00, 3'h0);
		vt_set <= 9'h0dc;
		count_high(PER);
		check("off mode", h, 0);
		for (int k = 0; k < 20; k++)
			exp_q.push_back(TK * (1 + 5 * k));
		apb(1'b1, 8'h00, 3'h2);
		wait_rise();
		while (exp_q.size() > 0) begin
			count_high(PER);
			check("ramp on time", h, exp_q.pop_front());
		end
		count_high(PER);
		check("full on", h, PER);
		volt_set <= 6'(5 + $urandom % 5);
		repeat (6) @(posedge clk_sys);
		count_high(PER);
		check("supply low", h, 0);
		volt_set <= 6'h0a;
		wait_rise();
		count_high(PER);
		check("restart pulse", h, TK);
		volt_set <= 6'(10 + $urandom % 39);
		apb(1'b1, 8'h00, 3'h6);
		repeat (4) @(posedge clk_sys);
		count_high(PER);
		check("direct on", h, PER);
		foreach (modes[i]) begin
			md = modes[i];
			// Warm inputs, so no stale demand is taken on mode entry
			vt_set <= 9'h12c;
			house_set <= 16'h0100;
			fail_set <= 1'b0;
			apb(1'b1, 8'h00, 3'h0);
			d = 0;
			apb(1'b1, 8'h00, 32'(md));
			repeat (6) begin
				v = 220 + $urandom % 101;
				hs = int'($urandom % 120) - 40;
				pf = $urandom % 2;
				vt_set <= 9'(v);
				house_set <= 16'(hs);
				fail_set <= 1'(pf);
				if (v < hsc_pkg::RST_LOW || pf == 1 && md == 9
					|| md > 2 && md < 6 && hs < int'(hsc_pkg::RST_HOUSE))
					d = 1;
				else if (v > hsc_pkg::RST_HIGH)
					d = 0;
				repeat (8) @(posedge clk_sys);
				count_high(PER);
				check("auto heat", 32'(h > 0), d);
			end
		end
		complete_run();
	end
endmodule
